// >>> carrier_model.sv
// Carrier board model: open-drain sideband drivers against module pull-ups
`timescale 1ns/10ps
`default_nettype none
`include "sideband_defines.svh"
module carrier_model (
   input  wire logic [8:0] gnd_in,
   input  wire logic       kick_gnd_in,
   input  wire logic       power_enable_in,
   output logic [8:0]      pin_out,
   output logic            kick_pin_out,
   output logic            circuits_on_out
);
   // Open drain: ground or float, the pull-up sets the idle high
   assign pin_out[5:0] = ~gnd_in[5:0];
   assign pin_out[`SB_CHARGING] = ~gnd_in[`SB_CHARGING];
   assign pin_out[`SB_CHARGER] = ~gnd_in[`SB_CHARGER];
   // Left floating unless a scenario asks for test functions
   assign pin_out[`SB_TEST] = ~gnd_in[`SB_TEST];
   assign kick_pin_out = ~kick_gnd_in;
   // Carrier circuits stay dark until enabled and while power is bad
   assign circuits_on_out = power_enable_in & pin_out[`SB_SUPPLY_FAULT];
endmodule
`default_nettype wire

// >>> module_power_sideband_watchdog.sv
// Module power sequencing, sideband inputs and hardware watchdog
`timescale 1ns/10ps
`default_nettype none
`include "sideband_defines.svh"
module module_power_sideband_watchdog #(
   parameter int unsigned DEBOUNCE_CYCLES = `DBNC_CYCLES
) (
   input  wire logic                  clk_sys_in,
   input  wire logic                  reset_in,
   input  wire logic                  input_supply_fault_n_in,
   input  wire logic                  reset_request_n_in,
   input  wire logic                  power_switch_n_in,
   input  wire logic                  sleep_request_n_in,
   input  wire logic                  lid_closed_n_in,
   input  wire logic                  battery_depleted_n_in,
   input  wire logic                  charging_n_in,
   input  wire logic                  charger_input_present_n_in,
   input  wire logic                  test_request_n_in,
   input  wire logic                  timer_kick_in_n,
   input  wire logic                  sw_kick_in,
   input  wire logic                  wdt_enable_in,
   input  wire sideband_pkg::wdt_count_t wdt_reload_in,
   output logic                       baseboard_power_enable_out,
   output logic                       baseboard_standby_n_out,
   output logic                       supply_enable_out,
   output logic                       general_reset_n_out,
   output logic                       module_reset_out,
   output logic                       power_switch_event_out,
   output logic                       lid_closed_out,
   output logic                       battery_low_out,
   output logic                       charging_out,
   output logic                       charger_present_out,
   output logic                       test_mode_out,
   output logic                       timer_event_out,
   output logic                       timer_expiry_out_n,
   output sideband_pkg::power_state_e power_state_out
);
   import sideband_pkg::*;

   localparam int unsigned RAMP_CYCLES = `RAMP_CYCLES;
   localparam int unsigned HOLD_CYCLES = `RST_HOLD_CYCLES;

   // Input filtering
   logic [`SB_COUNT-1:0] raw_n;
   logic [`SB_COUNT-1:0] sync_n;
   logic [`SB_COUNT-1:0] clean_n;
   logic [`SB_COUNT-1:0] fall;

   assign raw_n[`SB_SUPPLY_FAULT] = input_supply_fault_n_in;
   assign raw_n[`SB_RESET_REQ]    = reset_request_n_in;
   assign raw_n[`SB_POWER_SWITCH] = power_switch_n_in;
   assign raw_n[`SB_SLEEP]        = sleep_request_n_in;
   assign raw_n[`SB_LID]          = lid_closed_n_in;
   assign raw_n[`SB_BATTERY]      = battery_depleted_n_in;
   assign raw_n[`SB_CHARGING]     = charging_n_in;
   assign raw_n[`SB_CHARGER]      = charger_input_present_n_in;
   assign raw_n[`SB_TEST]         = test_request_n_in;

   genvar gi;
   generate
      for (gi = 0; gi < `SB_COUNT; gi++) begin : g_filter
         sideband_filter_if link ();
         assign link.raw_n = raw_n[gi];
         assign sync_n[gi]  = link.sync_n;
         assign clean_n[gi] = link.clean_n;
         assign fall[gi]    = link.fall;
         sideband_debounce #(
            .STABLE_CYCLES (DEBOUNCE_CYCLES)
         ) u_debounce (
            .clk_sys_in (clk_sys_in),
            .reset_in   (reset_in),
            .line       (link.filter)
         );
      end
   endgenerate

   // Kick gets a short filter; a long one would swallow legal pulses
   sideband_filter_if kick_link ();
   assign kick_link.raw_n = timer_kick_in_n;
   sideband_debounce #(
      .STABLE_CYCLES (`KICK_CYCLES)
   ) u_kick_filter (
      .clk_sys_in (clk_sys_in),
      .reset_in   (reset_in),
      .line       (kick_link.filter)
   );

   // Decoded conditions
   // Fault uses the synchronised level so rails drop without filter delay
   wire logic fault_sync    = ~sync_n[`SB_SUPPLY_FAULT];
   wire logic fault_active  = fault_sync | ~clean_n[`SB_SUPPLY_FAULT];
   wire logic reset_request = ~sync_n[`SB_RESET_REQ];
   wire logic switch_press  = fall[`SB_POWER_SWITCH];
   wire logic sleep_active  = ~clean_n[`SB_SLEEP];
   wire logic lid_close     = fall[`SB_LID];
   wire logic battery_low   = ~clean_n[`SB_BATTERY];
   wire logic internal_rst  = reset_in | reset_request;
   wire logic hw_kick       = kick_link.fall;
   wire logic kick_any      = hw_kick | sw_kick_in;

   // Power sequencer
   power_state_e state;
   power_state_e next_state;
   logic [31:0]  ramp_cnt;
   wire  logic   ramp_done = (ramp_cnt == 32'(RAMP_CYCLES - 1));

   always_comb begin
      next_state = state;
      case (state)
         PWR_OFF: begin
            if (switch_press && !battery_low)
               next_state = PWR_RAMP;
         end
         PWR_RAMP: begin
            if (ramp_done)
               next_state = PWR_RUN;
         end
         PWR_RUN: begin
            if (sleep_active || lid_close || switch_press || battery_low)
               next_state = PWR_STANDBY;
         end
         PWR_STANDBY: begin
            if (switch_press && !sleep_active && !battery_low)
               next_state = PWR_RUN;
         end
         default: next_state = PWR_OFF;
      endcase
      if (fault_active)
         next_state = PWR_OFF;
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in)
         state <= PWR_OFF;
      else
         state <= next_state;
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in || state != PWR_RAMP)
         ramp_cnt <= 32'h0;
      else
         ramp_cnt <= ramp_cnt + 32'h1;
   end

   // Carrier rails first; run rails only once the carrier side is up
   wire logic next_base_power = (next_state != PWR_OFF);
   wire logic next_run_rails  = (next_state == PWR_RUN) || (next_state == PWR_STANDBY);

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         baseboard_power_enable_out <= 1'b0;
         supply_enable_out          <= 1'b0;
         baseboard_standby_n_out    <= 1'b1;
      end else begin
         baseboard_power_enable_out <= next_base_power & ~fault_sync;
         supply_enable_out          <= next_run_rails & ~fault_sync;
         baseboard_standby_n_out    <= (next_state != PWR_STANDBY);
      end
   end

   // Reset outputs
   logic [15:0] hold_cnt;
   wire  logic  rst_cause = internal_rst | ~next_run_rails;

   always_ff @(posedge clk_sys_in) begin
      if (rst_cause)
         hold_cnt <= 16'(HOLD_CYCLES);
      else if (hold_cnt != 16'h0)
         hold_cnt <= hold_cnt - 16'h1;
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_cause)
         general_reset_n_out <= 1'b0;
      else
         general_reset_n_out <= (hold_cnt == 16'h0);
   end

   always_ff @(posedge clk_sys_in) begin
      module_reset_out <= internal_rst;
   end

   // Status outputs
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         power_switch_event_out <= 1'b0;
         lid_closed_out         <= 1'b0;
         battery_low_out        <= 1'b0;
         charging_out           <= 1'b0;
         charger_present_out    <= 1'b0;
         test_mode_out          <= 1'b0;
      end else begin
         power_switch_event_out <= switch_press;
         lid_closed_out         <= ~clean_n[`SB_LID];
         battery_low_out        <= battery_low;
         charging_out           <= ~clean_n[`SB_CHARGING];
         charger_present_out    <= ~clean_n[`SB_CHARGER];
         test_mode_out          <= ~clean_n[`SB_TEST];
      end
   end

   assign power_state_out = state;

   // Watchdog
   wdt_count_t wdt_cnt;
   logic       wdt_armed;
   logic       wdt_done;
   // One-cycle expiry: a counter parked at zero must not block the next kick
   wire  logic wdt_hit = wdt_enable_in & wdt_armed & (wdt_cnt == 32'h0) & ~wdt_done;

   always_ff @(posedge clk_sys_in) begin
      if (internal_rst) begin
         wdt_cnt   <= 32'h0;
         wdt_armed <= 1'b0;
         wdt_done  <= 1'b0;
      end else if (kick_any || (wdt_enable_in && !wdt_armed)) begin
         wdt_cnt   <= wdt_reload_in;
         wdt_armed <= 1'b1;
         wdt_done  <= 1'b0;
      end else if (!wdt_enable_in) begin
         wdt_armed <= 1'b0;
      end else if (wdt_cnt != 32'h0) begin
         wdt_cnt <= wdt_cnt - 32'h1;
      end else begin
         wdt_done <= 1'b1;
      end
   end

   // Expiry wins over a kick in the same cycle so no event is lost
   always_ff @(posedge clk_sys_in) begin
      if (internal_rst) begin
         timer_event_out    <= 1'b0;
         timer_expiry_out_n <= 1'b1;
      end else begin
         timer_event_out    <= wdt_hit | (timer_event_out & ~kick_any);
         timer_expiry_out_n <= ~(wdt_hit | (timer_event_out & ~kick_any));
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);

   property p_fault_rails;
      fault_sync |=> !baseboard_power_enable_out && !supply_enable_out;
   endproperty
   a_fault_rails: assert property (p_fault_rails) else $error("rail enabled during fault");

   property p_carrier_first;
      supply_enable_out |-> baseboard_power_enable_out;
   endproperty
   a_carrier_first: assert property (p_carrier_first) else $error("run rails before carrier");

   property p_standby;
      baseboard_standby_n_out == (state != PWR_STANDBY);
   endproperty
   a_standby: assert property (p_standby) else $error("standby output mismatch");

   property p_gen_reset;
      internal_rst |=> !general_reset_n_out [*2];
   endproperty
   a_gen_reset: assert property (p_gen_reset) else $error("general reset not held");

   property p_self_reset;
      reset_request |=> module_reset_out && !timer_event_out;
   endproperty
   a_self_reset: assert property (p_self_reset) else $error("module not held in reset");

   property p_switch_stable;
      switch_press |-> !sync_n[`SB_POWER_SWITCH] && !$past(sync_n[`SB_POWER_SWITCH]);
   endproperty
   a_switch_stable: assert property (p_switch_stable) else $error("switch acted unfiltered");

   property p_sleep_entry;
      (state == PWR_RUN) && sleep_active |=> state inside {PWR_STANDBY, PWR_OFF};
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("sleep request ignored");

   property p_lid;
      lid_closed_out == $past(~clean_n[`SB_LID]);
   endproperty
   a_lid: assert property (p_lid) else $error("lid status mismatch");

   property p_battery_hold;
      (state == PWR_OFF) && battery_low |=> state == PWR_OFF;
   endproperty
   a_battery_hold: assert property (p_battery_hold) else $error("powered up on low battery");

   property p_test;
      test_mode_out == $past(~clean_n[`SB_TEST]);
   endproperty
   a_test: assert property (p_test) else $error("test mode mismatch");

   property p_kick_reload;
      kick_any && !internal_rst |=> wdt_cnt == $past(wdt_reload_in);
   endproperty
   a_kick_reload: assert property (p_kick_reload) else $error("kick did not reload");

   property p_expire;
      wdt_hit && !internal_rst |=> timer_event_out && !timer_expiry_out_n;
   endproperty
   a_expire: assert property (p_expire) else $error("expiry not signalled");

   property p_event_hold;
      timer_event_out && !kick_any && !internal_rst |=> timer_event_out;
   endproperty
   a_event_hold: assert property (p_event_hold) else $error("event dropped without kick");

   property p_kick_clear;
      timer_event_out && kick_any && !wdt_hit && !internal_rst |=> !timer_event_out;
   endproperty
   a_kick_clear: assert property (p_kick_clear) else $error("kick did not clear event");

   c_run: cover property (state == PWR_RAMP ##1 state == PWR_RUN);
   c_standby: cover property (state == PWR_RUN ##1 state == PWR_STANDBY);
   c_expire: cover property ($rose(timer_event_out));
   c_fault_drop: cover property (state == PWR_RUN ##1 state == PWR_OFF);
endmodule
`default_nettype wire

// >>> sideband_debounce.sv
// Two-stage synchroniser and debounce filter for one active-low line
`timescale 1ns/10ps
`default_nettype none
module sideband_debounce #(
   parameter int unsigned STABLE_CYCLES = 4
) (
   input  wire logic        clk_sys_in,
   input  wire logic        reset_in,
   sideband_filter_if.filter line
);
   logic        meta_n;
   logic        sync_n;
   logic        clean_n;
   logic [31:0] cnt;
   wire  logic  differs   = (sync_n != clean_n);
   wire  logic  cnt_done  = (cnt == 32'(STABLE_CYCLES - 1));
   wire  logic  take      = differs & cnt_done;

   // Idle level is high: the module pull-up holds an undriven line inactive
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         meta_n <= 1'b1;
         sync_n <= 1'b1;
      end else begin
         meta_n <= line.raw_n;
         sync_n <= meta_n;
      end
   end

   // Any bounce back to the old level restarts the count
   always_ff @(posedge clk_sys_in) begin
      if (reset_in || !differs || take)
         cnt <= 32'h0;
      else
         cnt <= cnt + 32'h1;
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in)
         clean_n <= 1'b1;
      else if (take)
         clean_n <= sync_n;
   end

   assign line.sync_n  = sync_n;
   assign line.clean_n = clean_n;
   assign line.fall    = take & clean_n;
   assign line.rise    = take & ~clean_n;
endmodule
`default_nettype wire

// >>> sideband_defines.svh
// Constants for the module power sideband and watchdog block
// What this block does
// - Sideband inputs are active low; carrier floats or grounds, module pull-up idles high.
// - While supply fault is low, every supply enable stays off.
// - Baseboard power enable is asserted before other carrier circuits are powered.
// - Standby output is driven low in standby, released high otherwise.
// - Provide an active-low general reset output toward the carrier.
// - While the reset request input is low, the module holds itself in reset.
// - Power switch input is active low, debounced before use, and acts on the falling edge of the filtered level.
// - Sleep request input is active low and level sensitive.
// - Lid low means lid closed and may start sleep entry.
// - Battery depleted input low is treated as battery low.
// - Test input low invokes test functions; normally left unconnected.
// - Each low pulse on the kick input reloads and restarts the watchdog.
// - Watchdog expiry without any kick drives the event output high.
`ifndef SIDEBAND_DEFINES_SVH
`define SIDEBAND_DEFINES_SVH

`define CLK_MHZ           250
`define CLK_PERIOD_NS     4
// Filter time for slow carrier lines
`define DBNC_TIME_US      1000
`define DBNC_CYCLES       (`DBNC_TIME_US * `CLK_MHZ)
// Short filter for the kick line so brief pulses survive
`define KICK_FILTER_NS    16
`define KICK_CYCLES       (`KICK_FILTER_NS / `CLK_PERIOD_NS)
// Carrier rail settle time before the run rails come up
`define RAMP_TIME_US      10
`define RAMP_CYCLES       (`RAMP_TIME_US * `CLK_MHZ)
// Least width of the general reset output
`define RST_HOLD_US       1
`define RST_HOLD_CYCLES   (`RST_HOLD_US * `CLK_MHZ)

// Slots of the filtered sideband input array
`define SB_COUNT          9
`define SB_SUPPLY_FAULT   0
`define SB_RESET_REQ      1
`define SB_POWER_SWITCH   2
`define SB_SLEEP          3
`define SB_LID            4
`define SB_BATTERY        5
`define SB_CHARGING       6
`define SB_CHARGER        7
`define SB_TEST           8

`define WDT_WIDTH         32

`endif

// >>> sideband_filter_if.sv
// Carrier between one sideband filter and its user
`timescale 1ns/10ps
`default_nettype none
interface sideband_filter_if;
   logic raw_n;
   logic sync_n;
   logic clean_n;
   logic fall;
   logic rise;
   modport filter (input raw_n, output sync_n, output clean_n, output fall, output rise);
   modport user (output raw_n, input sync_n, input clean_n, input fall, input rise);
endinterface
`default_nettype wire

// >>> sideband_pkg.sv
// Types for the module power sideband and watchdog block
package sideband_pkg;
   typedef enum logic [1:0] {
      PWR_OFF     = 2'h0,
      PWR_RAMP    = 2'h1,
      PWR_RUN     = 2'h3,
      PWR_STANDBY = 2'h2
   } power_state_e;

   typedef logic [31:0] wdt_count_t;
endpackage

// >>> testbench.sv
// Self-checking bench for the power sideband and watchdog block
`timescale 1ns/10ps
`default_nettype none
`include "sideband_defines.svh"
module testbench;
   import sideband_pkg::*;
   logic         clk_sys_in = 1'b0;
   logic         reset_in;
   logic [8:0]   gnd;
   logic         kick_gnd;
   logic [8:0]   pin;
   logic         kick_pin;
   logic         circuits_on;
   logic         sw_kick;
   logic         wdt_en;
   wdt_count_t   reload;
   logic         pwr_en, stby_n, sup_en, grst_n, mrst, btn_ev, ev, exp_n;
   logic [4:0]   stat;
   power_state_e st;
   int           failures = 0;
   int           samples_checked = 0;

   carrier_model carrier_model_inst (.gnd_in(gnd), .kick_gnd_in(kick_gnd),
      .power_enable_in(pwr_en), .pin_out(pin), .kick_pin_out(kick_pin),
      .circuits_on_out(circuits_on));

   module_power_sideband_watchdog #(.DEBOUNCE_CYCLES(8)) module_power_sideband_watchdog_inst (
      .clk_sys_in(clk_sys_in), .reset_in(reset_in),
      .input_supply_fault_n_in(pin[`SB_SUPPLY_FAULT]),
      .reset_request_n_in(pin[`SB_RESET_REQ]), .power_switch_n_in(pin[`SB_POWER_SWITCH]),
      .sleep_request_n_in(pin[`SB_SLEEP]), .lid_closed_n_in(pin[`SB_LID]),
      .battery_depleted_n_in(pin[`SB_BATTERY]), .charging_n_in(pin[`SB_CHARGING]),
      .charger_input_present_n_in(pin[`SB_CHARGER]), .test_request_n_in(pin[`SB_TEST]),
      .timer_kick_in_n(kick_pin), .sw_kick_in(sw_kick), .wdt_enable_in(wdt_en),
      .wdt_reload_in(reload), .baseboard_power_enable_out(pwr_en),
      .baseboard_standby_n_out(stby_n), .supply_enable_out(sup_en),
      .general_reset_n_out(grst_n), .module_reset_out(mrst),
      .power_switch_event_out(btn_ev), .lid_closed_out(stat[0]), .battery_low_out(stat[1]),
      .charging_out(stat[2]), .charger_present_out(stat[3]), .test_mode_out(stat[4]),
      .timer_event_out(ev), .timer_expiry_out_n(exp_n), .power_state_out(st));

   initial begin
      forever #2 clk_sys_in = ~clk_sys_in;
   end

   task automatic results();
      if (failures == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask

   task automatic chk(input logic got, input logic exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask

   task automatic chk_st(input power_state_e exp, input string m);
      samples_checked++;
      if (st !== exp) begin
         failures++;
         $display("[FAIL] %0t state %s", $time, m);
      end
   endtask

   // Bounded wait; running out ends the run
   task automatic wait_bit(ref logic sig, input logic val, input int max, input string m);
      int i;
      for (i = 0; i < max && sig !== val; i++) cyc(1);
      if (sig !== val) begin
         failures++;
         $display("[FAIL] %0t timeout %s", $time, m);
         results();
      end
   endtask

   task automatic press();
      gnd[`SB_POWER_SWITCH] = 1'b1;
      wait_bit(btn_ev, 1'b1, 40, "button event");
      cyc(1);
      chk(btn_ev, 1'b0, "event one cycle");
      gnd[`SB_POWER_SWITCH] = 1'b0;
      cyc(14);
   endtask

   task automatic t_status();
      int k;
      // Glitch shorter than the filter must not get through
      gnd[`SB_LID] = 1'b1;
      cyc(5);
      gnd[`SB_LID] = 1'b0;
      cyc(16);
      chk(stat[0], 1'b0, "glitch filtered");
      for (k = 0; k < 5; k++) begin
         gnd[`SB_LID + k] = 1'b1;
         cyc(14);
         chk(stat[k], 1'b1, "status set");
         gnd[`SB_LID + k] = 1'b0;
         cyc(14);
         chk(stat[k], 1'b0, "status clear");
      end
      chk(sup_en, 1'b0, "rails stay off");
   endtask

   task automatic t_power_up();
      press();
      chk_st(PWR_RAMP, "ramp");
      chk(pwr_en, 1'b1, "carrier power on");
      chk(sup_en, 1'b0, "rails wait ramp");
      wait_bit(sup_en, 1'b1, 2600, "rails on");
      chk_st(PWR_RUN, "run");
      chk(grst_n, 1'b0, "reset held");
      chk(circuits_on, 1'b1, "carrier circuits on");
      wait_bit(grst_n, 1'b1, 300, "reset release");
      chk(stby_n, 1'b1, "standby released");
   endtask

   task automatic t_standby(input int slot);
      gnd[slot] = 1'b1;
      wait_bit(stby_n, 1'b0, 30, "enter standby");
      chk_st(PWR_STANDBY, "standby");
      gnd[slot] = 1'b0;
      cyc(14);
      press();
      wait_bit(stby_n, 1'b1, 30, "leave standby");
      chk_st(PWR_RUN, "back to run");
   endtask

   task automatic t_reset_req();
      gnd[`SB_RESET_REQ] = 1'b1;
      cyc(4);
      chk(mrst, 1'b1, "self reset");
      chk(grst_n, 1'b0, "general reset");
      chk_st(PWR_RUN, "state kept");
      cyc(10);
      chk(mrst, 1'b1, "reset held while low");
      gnd[`SB_RESET_REQ] = 1'b0;
      wait_bit(mrst, 1'b0, 20, "self reset end");
      wait_bit(grst_n, 1'b1, 300, "general reset end");
   endtask

   task automatic t_watchdog();
      int k;
      reload = 32'h0000_0014;
      wdt_en = 1'b1;
      cyc(15);
      chk(ev, 1'b0, "no early expiry");
      wait_bit(ev, 1'b1, 15, "expiry");
      chk(exp_n, 1'b0, "expiry low");
      cyc(30);
      chk(ev, 1'b1, "event sticky");
      for (k = 0; k < 6; k++) begin
         kick_gnd = 1'b1;
         cyc(8);
         kick_gnd = 1'b0;
         cyc(6);
         chk(ev, 1'b0, "hardware kick");
      end
      for (k = 0; k < 6; k++) begin
         sw_kick = 1'b1;
         cyc(1);
         sw_kick = 1'b0;
         cyc(9);
         chk(ev, 1'b0, "software kick");
      end
      wdt_en = 1'b0;
      cyc(60);
      chk(ev, 1'b0, "disabled never expires");
   endtask

   task automatic t_fault();
      int i;
      logic bad;
      bad = 1'b0;
      gnd[`SB_SUPPLY_FAULT] = 1'b1;
      cyc(4);
      chk(sup_en, 1'b0, "rails drop");
      chk(pwr_en, 1'b0, "carrier power drops");
      chk(circuits_on, 1'b0, "carrier circuits dark");
      chk_st(PWR_OFF, "off on fault");
      press();
      for (i = 0; i < 2700; i++) begin
         cyc(1);
         if (sup_en !== 1'b0) bad = 1'b1;
      end
      chk(bad, 1'b0, "no rails while fault");
      gnd[`SB_SUPPLY_FAULT] = 1'b0;
      cyc(5);
   endtask

   initial begin
      reset_in = 1'b1;
      gnd = 9'h000;
      kick_gnd = 1'b0;
      sw_kick = 1'b0;
      wdt_en = 1'b0;
      reload = 32'h0000_0000;
      cyc(4);
      chk(sup_en, 1'b0, "reset rails");
      chk(grst_n, 1'b0, "reset general");
      chk(stby_n, 1'b1, "reset standby");
      chk(exp_n, 1'b1, "reset expiry");
      chk_st(PWR_OFF, "reset");
      reset_in = 1'b0;
      cyc(2);
      t_status();
      t_power_up();
      t_standby(`SB_SLEEP);
      t_standby(`SB_LID);
      t_standby(`SB_BATTERY);
      t_reset_req();
      t_watchdog();
      t_fault();
      results();
   end
endmodule
`default_nettype wire
